// ### include/cchs_pkg.sv
// Package for the core clock halving select block: register map and cycle constants.
package cchs_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CORE_CLOCK_CONTROL_ADDR = 8'h8f;  // Clock control register.
  localparam int         SPEED_BIT               = 0;      // Position of the speed-select bit.
  localparam logic       SPEED_RESET             = 1'b0;   // Standard mode after reset.
  localparam logic [6:0] RESERVED_READ           = 7'h00;  // Reserved bits read as zero.

  // ************************************************************
  // Machine cycle lengths in crystal periods
  // ************************************************************
  localparam logic [3:0] STANDARD_PERIODS = 4'hc;  // Periods per machine cycle, standard mode.
  localparam logic [3:0] DOUBLE_PERIODS   = 4'h6;  // Periods per machine cycle, double speed.
  localparam logic [3:0] PHASE_LAST  = 4'h5;  // Last phase index of a six-tick cycle.

  // Mode of the switched clock.
  typedef enum logic {
    CCHS_STANDARD,
    CCHS_DOUBLE
  } cchs_mode_e;

  // Register bus request carrier.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cchs_req_s;

endpackage

// ### logic/cchs_core_clock.sv
// Crystal clock halving and double-speed selection feeding the core phase generator.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

module cchs_core_clock (
  input  wire logic              clk,          // Crystal input clock, crystal_input.
  input  wire logic              rst,          // Device reset, synchronous, active high.
  input  wire logic              ce,           // Clock enable; low freezes all state.
  input  wire cchs_pkg::cchs_req_s req,        // Register bus request.
  input  wire logic              idle,         // Core is in idle mode.
  output logic [7:0]             rdata,        // Read data, one cycle after the read strobe.
  output logic                   core_tick,    // Tick to core and peripherals; crystal rate in double speed, half that in standard mode.
  output logic                   cycle_end,    // Pulse on the last tick of a machine cycle.
  output logic                   double_speed  // Mode in force, 1 for double speed.
);

  // ************************************************************
  // Register file
  // ************************************************************
  logic                 sel_q, sel_d;      // Software speed-select bit (requested mode).
  logic [7:0]           rdata_q, rdata_d;  // Read data register.
  cchs_pkg::cchs_mode_e mode_q, mode_d;    // Mode in force, read back by software.

  // Address match of the clock control register; the write and read paths share it.
  function automatic logic hits_control(input logic [7:0] addr);
    hits_control = (addr == cchs_pkg::CORE_CLOCK_CONTROL_ADDR);
  endfunction

  // Software writes the request; reads show the mode actually in force.
  always_comb begin
    sel_d   = sel_q;
    rdata_d = 8'h00;
    if (req.wr && hits_control(req.addr)) begin
      sel_d = req.wdata[cchs_pkg::SPEED_BIT];
    end
    if (req.rd && hits_control(req.addr)) begin
      rdata_d = {cchs_pkg::RESERVED_READ, mode_q == cchs_pkg::CCHS_DOUBLE};
    end
  end

  // ************************************************************
  // Halving stage and glitch-free switch
  // ************************************************************
  logic                 half_q, half_d;    // Crystal divided by two.
  logic                 ds_q, ds_d;        // Registered copy of the mode for the output pin.
  logic                 tick_q, tick_d;
  logic [3:0]           phase_q, phase_d;  // Phase counter of the generator.
  logic                 end_q, end_d;

  // The request is sampled only where the halved clock rises, i.e. when half goes 0->1;
  // at that boundary both sources have just completed a low phase, so no short pulse.
  always_comb begin
    half_d  = ~half_q;
    mode_d  = mode_q;
    if (!half_q) begin
      mode_d = sel_q ? cchs_pkg::CCHS_DOUBLE : cchs_pkg::CCHS_STANDARD;
    end
    // Standard mode ticks once per halved period; double speed every crystal period.
    ds_d    = (mode_d == cchs_pkg::CCHS_DOUBLE);
    tick_d  = (mode_d == cchs_pkg::CCHS_DOUBLE) ? 1'b1 : half_d;
    phase_d = phase_q;
    end_d   = 1'b0;
    if (tick_d) begin
      if (phase_q == cchs_pkg::PHASE_LAST) begin
        phase_d = 4'h0;
        end_d   = 1'b1;
      end else begin
        phase_d = phase_q + 4'h1;
      end
    end
  end

  // Register file state; a frozen enable holds the pending request and the read data.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q   <= cchs_pkg::SPEED_RESET;
      rdata_q <= 8'h00;
    end else if (ce) begin
      sel_q   <= sel_d;
      rdata_q <= rdata_d;
    end
  end

  // Clock path state; idle does not stop it, so the mode may change in idle too.
  always_ff @(posedge clk) begin
    if (rst) begin
      half_q  <= 1'b0;
      mode_q  <= cchs_pkg::CCHS_STANDARD;
      ds_q    <= 1'b0;
      tick_q  <= 1'b0;
      phase_q <= 4'h0;
      end_q   <= 1'b0;
    end else if (ce) begin
      half_q  <= half_d;
      mode_q  <= mode_d;
      ds_q    <= ds_d;
      tick_q  <= tick_d;
      phase_q <= phase_d;
      end_q   <= end_d;
    end
  end

  // Every output leaves straight from a flip-flop, so downstream timing sees no decode.
  assign rdata        = rdata_q;
  assign core_tick    = tick_q;
  assign cycle_end    = end_q;
  assign double_speed = ds_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic [4:0] gap_q;  // Crystal cycles since the last machine-cycle end.
  always_ff @(posedge clk) begin
    if (rst || (ce && end_q)) begin
      gap_q <= 5'h0;
    end else if (ce && gap_q != 5'h1f) begin
      gap_q <= gap_q + 5'h1;
    end
  end

  // ************************************************************
  // Notes for integration
  // ************************************************************
  // The block never makes a real clock: core_tick is an enable on the crystal clock,
  // so every downstream flop stays in one domain and no gated clock can glitch.
  // A mode request written just after a halved edge waits up to two more crystal periods.
  // The idle input is only observed here; idle never slows or stops the clock path.
  // Reserved bits read back as zero, a stronger promise than software may rely on.
  // The enable freezes the halver too, so a frozen block resumes in the same phase.

  // Enabled cycles since the mode in force last changed, saturating; it lets the
  // standard-mode cycle-length check skip the machine cycles that end before it saturates after a switch.
  logic [4:0] steady_q;
  always_ff @(posedge clk) begin
    if (rst || (ce && mode_d != mode_q)) begin
      steady_q <= 5'h0;
    end else if (ce && steady_q != 5'h1f) begin
      steady_q <= steady_q + 5'h1;
    end
  end

  // The mode in force only moves where the halved clock rises.
  a_mode_on_edge: assert property (@(posedge clk) disable iff (rst)
    $changed(mode_q) |-> $past(half_q) == 1'b0) else $error("Mode changed off the halved edge.");

  // Standard mode never ticks in two enabled cycles in a row.
  a_standard_tick_rate: assert property (@(posedge clk) disable iff (rst)
    (ce && tick_q && !double_speed) ##1 ce |-> !tick_q) else $error("Standard mode ticked twice.");

  // Double speed ticks on every enabled crystal period.
  a_double_tick_rate: assert property (@(posedge clk) disable iff (rst)
    double_speed && $past(double_speed) && $past(ce) |-> tick_q) else $error("Double speed missed a tick.");

  // A whole double-speed machine cycle lasts six crystal periods.
  a_double_cycle_len: assert property (@(posedge clk) disable iff (rst || !ce)
    end_q && double_speed && $past(double_speed, 6) && gap_q > 5'h0
    |-> gap_q == 5'(cchs_pkg::DOUBLE_PERIODS - 4'h1))
    else $error("Double-speed cycle not six periods.");

  // A whole standard machine cycle lasts twelve crystal periods.
  a_standard_cycle_len: assert property (@(posedge clk) disable iff (rst || !ce)
    end_q && !double_speed && steady_q == 5'h1f
    |-> gap_q == 5'(cchs_pkg::STANDARD_PERIODS - 4'h1))
    else $error("Standard cycle not twelve periods.");

  // Reset leaves the block in standard mode with the request cleared.
  a_reset_standard: assert property (@(posedge clk)
    $past(rst) |-> !double_speed && sel_q == 1'b0) else $error("Reset left double speed.");

  // Reserved bits of a read are always zero.
  a_read_resv: assert property (@(posedge clk) disable iff (rst)
    $past(req.rd) |-> rdata[7:1] == cchs_pkg::RESERVED_READ) else $error("Reserved bits nonzero.");

  // An unmapped read returns an all-zero byte.
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    $past(req.rd) && $past(ce) && !$past(rst) && $past(req.addr) != cchs_pkg::CORE_CLOCK_CONTROL_ADDR
    |-> rdata == 8'h00) else $error("Unmapped read not zero.");

  // A taken write lands in the request bit.
  a_write_take: assert property (@(posedge clk) disable iff (rst)
    ce && req.wr && req.addr == cchs_pkg::CORE_CLOCK_CONTROL_ADDR
    |=> sel_q == $past(req.wdata[cchs_pkg::SPEED_BIT]))
    else $error("Speed bit write lost.");

  // A taken read shows the mode that stood when the strobe was taken.
  a_read_mode: assert property (@(posedge clk) disable iff (rst)
    $past(req.rd) && $past(ce) && !$past(rst) && $past(req.addr) == cchs_pkg::CORE_CLOCK_CONTROL_ADDR
    |-> rdata[cchs_pkg::SPEED_BIT] == $past(double_speed)) else $error("Read lost the mode in force.");

  // Entering double speed happens only after a low phase of the halved tick.
  a_switch_low: assert property (@(posedge clk) disable iff (rst)
    $changed(mode_q) |-> $past(tick_q) == 1'b0 || $past(double_speed)) else $error("Switch cut a pulse.");

  // The halving stage toggles on every enabled crystal period.
  a_halver_toggles: assert property (@(posedge clk) disable iff (rst)
    ce |=> half_q != $past(half_q)) else $error("Halving stage stalled.");

  // A machine cycle ends only on a tick.
  a_end_on_tick: assert property (@(posedge clk) disable iff (rst)
    end_q |-> tick_q) else $error("Cycle end without a tick.");

  // The phase counter stays inside one machine cycle.
  a_phase_range: assert property (@(posedge clk) disable iff (rst)
    phase_q <= cchs_pkg::PHASE_LAST) else $error("Phase counter out of range.");

  // A low enable freezes the clock path and the request.
  a_freeze_hold: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(half_q) && $stable(phase_q) && $stable(sel_q)) else $error("Frozen state moved.");

  // Main scenarios: both switches, full cycles in both modes, a switch in idle.
  c_to_double: cover property (@(posedge clk) $rose(double_speed));
  c_to_standard: cover property (@(posedge clk) $fell(double_speed));
  c_double_cycle: cover property (@(posedge clk) end_q && double_speed);
  c_standard_cycle: cover property (@(posedge clk) end_q && !double_speed && steady_q == 5'h1f);
  c_idle_switch: cover property (@(posedge clk) idle && $changed(double_speed));

endmodule

// ### verification/cchs_phase_model.sv
// Phase generator model: measures crystal periods per machine cycle.
`timescale 1ns/1ps

module cchs_phase_model (
  input  wire logic       clk,       // Crystal input clock.
  input  wire logic       cycle_end, // End of a machine cycle.
  output logic      [4:0] periods    // Periods in the last machine cycle.
);
  logic [4:0] cnt_q = 5'h00;
  logic [4:0] per_q = 5'h00;
  // Restart at each cycle end; counting crystal edges catches both modes alike.
  always_ff @(posedge clk) begin
    cnt_q <= cycle_end ? 5'h01 : cnt_q + 5'h01;
    if (cycle_end) per_q <= cnt_q;
  end
  assign periods = per_q;
endmodule

// ### verification/core_clock_halving_select_test.sv
// Testbench for the core clock halving select block.
`timescale 1ns/1ps

module core_clock_halving_select_test;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                ce = 1'b1;
  logic                idle = 1'b0;
  cchs_pkg::cchs_req_s req = '0;
  logic [7:0]          rdata;
  logic                core_tick, cycle_end, double_speed, rd_d = 1'b0;
  logic [4:0]          periods;
  logic                tick_seen = 1'b0;
  logic [7:0]          exp_q[$];
  int                  mismatches = 0, checks = 0;
  localparam logic [7:0] A = cchs_pkg::CORE_CLOCK_CONTROL_ADDR;

  always #2.5 clk = ~clk;
  cchs_core_clock uut (.clk(clk), .rst(rst), .ce(ce), .req(req), .idle(idle), .rdata(rdata),
    .core_tick(core_tick), .cycle_end(cycle_end), .double_speed(double_speed));
  cchs_phase_model far (.clk(clk), .cycle_end(cycle_end), .periods(periods));

  // ****************************************
  // Bus tasks and result checking
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so compare there.
  always @(posedge clk) begin
    if (rd_d) check(rdata, exp_q.pop_front());
    rd_d <= req.rd && ce;
  end

  // Main sequence.
  initial begin
    void'($urandom(39));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(A, 8'h00);
    rd(8'h8e, 8'h00);
    repeat (40) @(posedge clk);
    #1 check(8'(periods), 8'd12);
    $display("reset test done");
    @(posedge clk) ce <= 1'b0;
    wr(A, 8'h01);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    check({7'h00, double_speed}, 8'h00);
    $display("freeze test done");
    for (int i = 0; i < 4; i++) begin
      idle <= 1'($urandom % 2);
      wr(A, {7'h00, !i[0]});
      repeat (3) @(posedge clk);
      #1 check({7'h00, double_speed}, {7'h00, !i[0]});
      rd(A, {7'h00, !i[0]});
      repeat (40) @(posedge clk);
      #1 check(8'(periods), i[0] ? 8'd12 : 8'd6);
      tick_seen = core_tick;
      @(posedge clk) #1 check(8'(2'(tick_seen) + 2'(core_tick)), i[0] ? 8'd1 : 8'd2);
      @(posedge clk);
      $display("switch test %0d done", i);
    end
    wrap_up();
  end

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    #20us;
    mismatches++;
    wrap_up();
  end
endmodule
